/* File: hdl/vst_pkg.sv */
// shared constants and types for the video sync timing outputs
package vst_pkg;

    // ************************************************************
    // format classes and carriers
    // ************************************************************
    typedef enum logic [1:0]
    {
        VST_SD = 2'b00,
        VST_ED = 2'b01,
        VST_HD = 2'b11
    } vst_class_e;

    typedef struct packed
    {
        vst_class_e fmt_class;
        logic       interlaced;
    } vst_fmt_s;

    typedef struct packed
    {
        logic line_sync;
        logic field_sync;
        logic back_porch_gate;
        logic field_parity;
        logic line_count_serial;
    } vst_out_s;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 125;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int BP_DELAY_NS    = 200;
    localparam int BP_SD_WIDTH_NS = 2240;
    localparam int BP_ED_WIDTH_NS = 1120;
    localparam int BP_HD_WIDTH_NS = 560;
    localparam int NO_VIDEO_NS    = 200000;

    localparam int BP_DELAY_CYC    = ns_to_cyc(BP_DELAY_NS);
    localparam int BP_SD_WIDTH_CYC = ns_to_cyc(BP_SD_WIDTH_NS);
    localparam int BP_ED_WIDTH_CYC = ns_to_cyc(BP_ED_WIDTH_NS);
    localparam int BP_HD_WIDTH_CYC = ns_to_cyc(BP_HD_WIDTH_NS);
    localparam int NO_VIDEO_CYC    = ns_to_cyc(NO_VIDEO_NS);

    // ************************************************************
    // line count framing
    // ************************************************************
    localparam int LINE_CNT_W  = 11;
    localparam int VF_FIRST    = 3;
    localparam int VF_LAST     = VF_FIRST + LINE_CNT_W - 1;
    localparam int FIELD_LINES = 3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam vst_out_s OUT_RESET = 5'b11111;

endpackage

/* File: hdl/vst_edge_sync.sv */
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
module vst_edge_sync
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // asynchronous input
    input  wire logic async_in,
    // synchronised level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic prev;

    // only sync reads meta
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= async_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise  = sync & ~prev;
    assign fall  = ~sync & prev;

endmodule // vst_edge_sync

/* File: hdl/vst_timing_outputs.sv */
// timing outputs of the sync separator, from sliced sync events
// What this block does
// - line sync falls on each sliced sync leading edge 3/4 line or more after the last one, after a fixed delay.
// - in vertical interval, line sync rising edges follow broad serration pulses.
// - field sync falls at the first broad serration pulse, after a delay.
// - field sync stays low about three line periods.
// - back-porch gate pulses low, fixed width, after each sync pulse.
// - SD gate starts after sync rising edge, wide enough for burst.
// - SD gate is shortened during the vertical interval.
// - ED gate behaves like SD but always uses the short width.
// - HD gate starts after tri-level trailing fall, with narrowest width.
// - interlaced parity high in field 1, low in field 2.
// - in interlaced formats, parity changes only at the field sync falling edge.
// - progressive formats hold parity high.
// - line syncs per field are counted and sent as 11-bit binary.
// - bits go out on 11 line edges from the 3rd after field sync.
// - serial output outside the 11 bit times holds the last bit sent.
// - line syncs during field sync are not counted.
// - counts come out as input line totals minus the field sync lines.
// - without video, line, field and gate outputs stay high.
`timescale 1ns/1ps
module vst_timing_outputs
#(
    parameter int PER_W        = 16,
    parameter int NO_VIDEO_CYC = vst_pkg::NO_VIDEO_CYC
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // sliced sync from the slicer, asynchronous
    input  wire logic              sync_tip_in,
    input  wire logic              sync_pos_in,
    // format from the detector, same clock
    input  wire vst_pkg::vst_fmt_s fmt,
    // timing outputs
    output vst_pkg::vst_out_s      sync_out
);
    // ************************************************************
    // checks and types
    // ************************************************************
    if (PER_W < 14 || PER_W > 28)
    begin : g_bad_per_w
        $error("PER_W must be 14 to 28");
    end
    if (NO_VIDEO_CYC < 2 || NO_VIDEO_CYC >= (1 << 20))
    begin : g_bad_no_video
        $error("NO_VIDEO_CYC out of range");
    end

    typedef enum logic [1:0]
    {
        BP_IDLE  = 2'b00,
        BP_DELAY = 2'b01,
        BP_GATE  = 2'b11
    } vst_bp_e;

    localparam int VS_W = PER_W + 2;

    function automatic logic [PER_W-1:0] sat_inc(input logic [PER_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // ************************************************************
    // input sync
    // ************************************************************
    logic tip;
    logic tip_rise;
    logic tip_fall;
    logic pos_fall;

    vst_edge_sync u_tip
    (
        .clock    (clock),
        .rst      (rst),
        .async_in (sync_tip_in),
        .level    (tip),
        .rise     (tip_rise),
        .fall     (tip_fall)
    );

    vst_edge_sync u_pos
    (
        .clock    (clock),
        .rst      (rst),
        .async_in (sync_pos_in),
        .level    (),
        .rise     (),
        .fall     (pos_fall)
    );

    // ************************************************************
    // state
    // ************************************************************
    // one flop per output, so no packed struct has several drivers
    logic                    line_sync;
    logic                    field_sync;
    logic                    back_porch_gate;
    logic                    field_parity;
    logic                    line_count_serial;
    logic                    have_lead;
    logic [PER_W-1:0]        since_lead;
    logic [PER_W-1:0]        line_period;
    logic [PER_W-1:0]        tip_time;
    logic [19:0]             idle_cnt;
    logic [VS_W-1:0]         vs_cnt;
    logic [vst_pkg::LINE_CNT_W-1:0] line_cnt;
    logic [vst_pkg::LINE_CNT_W-1:0] captured;
    logic [3:0]              edge_idx;
    vst_bp_e                 bp_state;
    logic [PER_W-1:0]        bp_cnt;

    // ************************************************************
    // decode
    // ************************************************************
    wire       present     = idle_cnt < 20'(NO_VIDEO_CYC);
    wire [PER_W-1:0] quarter = line_period >> 2;
    // half-line equalising and broad pulses must not restart the line
    wire       accept_lead = tip_rise && (line_period == '0 || since_lead >= line_period - quarter);
    wire       in_vs       = ~field_sync;
    wire       broad       = tip && line_period != '0 && tip_time == quarter && !in_vs;
    wire       vs_start    = broad && present;
    wire       field_one   = since_lead < (line_period >> 1);
    wire [3:0] next_edge   = (edge_idx == 4'hf) ? edge_idx : edge_idx + 4'h1;
    wire       vf_active   = next_edge >= 4'(vst_pkg::VF_FIRST) && next_edge <= 4'(vst_pkg::VF_LAST);
    wire [3:0] vf_bit      = 4'(vst_pkg::VF_LAST) - next_edge;
    wire       bp_trigger  = (fmt.fmt_class == vst_pkg::VST_HD) ? pos_fall : tip_fall;
    wire [PER_W-1:0] bp_width =
        (fmt.fmt_class == vst_pkg::VST_HD) ? PER_W'(vst_pkg::BP_HD_WIDTH_CYC) :
        (fmt.fmt_class == vst_pkg::VST_ED || in_vs) ? PER_W'(vst_pkg::BP_ED_WIDTH_CYC) :
        PER_W'(vst_pkg::BP_SD_WIDTH_CYC);
    wire [VS_W-1:0] vs_len = VS_W'(line_period) * VS_W'(vst_pkg::FIELD_LINES);

    // ************************************************************
    // line timing measurement
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            since_lead  <= '0;
            line_period <= '0;
            tip_time    <= '0;
            idle_cnt    <= '0;
            have_lead   <= 1'b0;
        end
        else
        begin
            since_lead <= accept_lead ? PER_W'(1) : sat_inc(since_lead);
            // time since reset is no line period: wait for a second lead
            if (accept_lead)
                have_lead <= 1'b1;
            if (accept_lead && !in_vs && have_lead)
                line_period <= since_lead;
            tip_time <= tip_rise ? '0 : (tip ? sat_inc(tip_time) : tip_time);
            if (tip_rise || tip_fall)
                idle_cnt <= '0;
            else if (present)
                idle_cnt <= idle_cnt + 20'h1;
        end
    end

    // ************************************************************
    // line sync and field sync
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_sync  <= vst_pkg::OUT_RESET.line_sync;
            field_sync <= vst_pkg::OUT_RESET.field_sync;
            vs_cnt     <= '0;
        end
        else
        begin
            // pin to output is three clocks: two sync flops and this one
            if (!present)
                line_sync <= 1'b1;
            else if (accept_lead)
                line_sync <= 1'b0;
            else if (tip_fall)
                line_sync <= 1'b1;
            if (!present)
            begin
                field_sync <= 1'b1;
                vs_cnt     <= '0;
            end
            else if (vs_start)
            begin
                field_sync <= 1'b0;
                vs_cnt     <= vs_len;
            end
            else if (in_vs)
            begin
                vs_cnt <= vs_cnt - 1'b1;
                if (vs_cnt <= VS_W'(1))
                    field_sync <= 1'b1;
            end
        end
    end

    // ************************************************************
    // field parity
    // ************************************************************
    // in interlaced formats, moves only together with the field sync leading edge
    always_ff @(posedge clock)
    begin
        if (rst)
            field_parity <= vst_pkg::OUT_RESET.field_parity;
        else if (!fmt.interlaced)
            field_parity <= 1'b1;
        else if (vs_start)
            field_parity <= field_one;
    end

    // ************************************************************
    // line count and serial output
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_cnt                <= '0;
            captured                <= '0;
            edge_idx                <= 4'hf;
            line_count_serial       <= vst_pkg::OUT_RESET.line_count_serial;
        end
        else if (vs_start)
        begin
            captured <= line_cnt;
            line_cnt <= '0;
            edge_idx <= '0;
        end
        else if (accept_lead)
        begin
            if (!in_vs)
                line_cnt <= line_cnt + 1'b1;
            edge_idx <= next_edge;
            // outside the bit times the last bit just stays
            if (vf_active)
                line_count_serial <= captured[vf_bit];
        end
    end

    // ************************************************************
    // back porch gate
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bp_state              <= BP_IDLE;
            bp_cnt                <= '0;
            back_porch_gate       <= vst_pkg::OUT_RESET.back_porch_gate;
        end
        else
        begin
            case (bp_state)
                BP_IDLE:
                    if (bp_trigger && present)
                    begin
                        bp_state <= BP_DELAY;
                        bp_cnt   <= PER_W'(vst_pkg::BP_DELAY_CYC);
                    end
                BP_DELAY:
                    if (bp_cnt <= PER_W'(1))
                    begin
                        bp_state              <= BP_GATE;
                        bp_cnt                <= bp_width;
                        back_porch_gate       <= 1'b0;
                    end
                    else
                        bp_cnt <= bp_cnt - 1'b1;
                BP_GATE:
                    if (bp_cnt <= PER_W'(1) || !present)
                    begin
                        bp_state              <= BP_IDLE;
                        back_porch_gate       <= 1'b1;
                    end
                    else
                        bp_cnt <= bp_cnt - 1'b1;
                default:
                    bp_state <= BP_IDLE;
            endcase
        end
    end

    // ************************************************************
    // output carrier
    // ************************************************************
    assign sync_out = '{
        line_sync:         line_sync,
        field_sync:        field_sync,
        back_porch_gate:   back_porch_gate,
        field_parity:      field_parity,
        line_count_serial: line_count_serial
    };

endmodule // vst_timing_outputs

/* File: tb/vst_out_checker.sv */
// concurrent checks on the timing outputs
`timescale 1ns/1ps
module vst_out_checker
#(
    parameter int NO_VIDEO_CYC = 2000
)
(
    // clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // inputs of the block
    input wire logic              sync_tip_in,
    input wire logic              sync_pos_in,
    input wire vst_pkg::vst_fmt_s fmt,
    // outputs of the block
    input wire vst_pkg::vst_out_s sync_out
);
    wire logic ls = sync_out.line_sync;
    wire logic fs = sync_out.field_sync;
    wire logic bp = sync_out.back_porch_gate;
    wire logic par = sync_out.field_parity;
    logic      ls_d;
    logic      tip_d;
    int        ls_cnt, per, fs_len, bp_len, tip_hi, idle;
    wire logic ls_fall = ls_d && !ls;
    // period taken outside field sync only, as the block does
    always_ff @(posedge clock)
    begin
        ls_d   <= ls;
        tip_d  <= sync_tip_in;
        ls_cnt <= (rst || ls_fall) ? 1 : ls_cnt + 1;
        per    <= (ls_fall && fs) ? ls_cnt : per;
        fs_len <= fs ? 0 : fs_len + 1;
        bp_len <= bp ? 0 : bp_len + 1;
        tip_hi <= sync_tip_in ? tip_hi + 1 : 0;
        idle   <= (rst || sync_tip_in != tip_d) ? 0 : idle + 1;
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    ls_lead_a:
        assert property ($fell(ls) |-> $past(sync_tip_in, 3) && !$past(sync_tip_in, 4))
        else $error("line sync fall misplaced");
    ls_trail_a:
        assert property ($fell(sync_tip_in) && !ls |-> ##4 ls)
        else $error("line sync rise late");
    fs_start_a:
        assert property ($fell(fs) |-> sync_tip_in && tip_hi >= per / 4 && tip_hi <= per / 4 + 8)
        else $error("field sync start misplaced");
    fs_width_a:
        assert property ($rose(fs) |-> fs_len >= 3 * per - 2 && fs_len <= 3 * per + 2)
        else $error("field sync width wrong");
    par_edge_a:
        assert property ($changed(par) |-> $fell(fs))
        else $error("parity moved off field start");
    prog_par_a:
        assert property ($fell(fs) && !fmt.interlaced |-> par)
        else $error("progressive parity low");
    ser_edge_a:
        assert property ($changed(sync_out.line_count_serial) |-> $fell(ls))
        else $error("serial bit moved off line edge");
    idle_high_a:
        assert property (idle > NO_VIDEO_CYC + 8 |-> ls && fs && bp)
        else $error("outputs low without video");
    gate_hd_a:
        assert property ($rose(bp) && fmt.fmt_class == vst_pkg::VST_HD |->
            bp_len >= vst_pkg::BP_HD_WIDTH_CYC - 1 && bp_len <= vst_pkg::BP_HD_WIDTH_CYC + 1)
        else $error("hd gate width wrong");
    cover property ($fell(fs) && !par);
    cover property ($rose(bp) && fmt.fmt_class == vst_pkg::VST_HD);
    cover property (idle == NO_VIDEO_CYC);
endmodule // vst_out_checker

bind vst_timing_outputs vst_out_checker #(.NO_VIDEO_CYC(NO_VIDEO_CYC)) u_chk
(
    .clock(clock),
    .rst(rst),
    .sync_tip_in(sync_tip_in),
    .sync_pos_in(sync_pos_in),
    .fmt(fmt),
    .sync_out(sync_out)
);

/* File: tb/vst_count_rx.sv */
// far-side decoder of the serial line count
`timescale 1ns/1ps
module vst_count_rx
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst,
    // timing outputs of the block
    input  wire logic   line_sync,
    input  wire logic   field_sync,
    input  wire logic   serial,
    // count decoded in the last field, and its composite flag
    output logic [10:0] count,
    output logic        composite
);
    wire logic   ref_clk = ~line_sync;
    logic        ref_d;
    logic        fs_d;
    logic [10:0] shift;
    int          n;
    int          dly;
    // sample mid-line, far from the bit changes
    always_ff @(posedge clock)
    begin
        ref_d <= ref_clk;
        fs_d  <= field_sync;
        dly   <= (ref_clk && !ref_d) ? 200 : (dly > 0 ? dly - 1 : 0);
        if (rst) n <= 99;
        else if (fs_d && !field_sync) n <= 0;
        else if (ref_clk && !ref_d) n <= n + 1;
        if (dly == 1 && n >= 3 && n <= 13) shift <= {shift[9:0], serial};
        if (dly == 1 && n == 13) count <= {shift[9:0], serial};
        if (dly == 1 && n == 5) composite <= serial;
    end
endmodule // vst_count_rx

/* File: tb/vst_timing_outputs_tb.sv */
// bench for the timing outputs with a far-side count decoder
`timescale 1ns/1ps
module vst_timing_outputs_tb;
    // ************************************************************
    // signals and bookkeeping
    // ************************************************************
    localparam int L = 400;
    localparam int D = vst_pkg::BP_DELAY_CYC;
    logic              clock = 1'h0;
    logic              rst = 1'h1;
    logic              sync_tip_in = 1'h0;
    logic              sync_pos_in = 1'h0;
    vst_pkg::vst_fmt_s fmt = '{vst_pkg::VST_SD, 1'h0};
    vst_pkg::vst_out_s so;
    logic [4:0]        so_d = 5'h1f;
    logic [10:0]       rx_count;
    logic              rx_comp;
    int                cyc = 0;
    int                err_count = 0;
    int                total_checks = 0;
    int                tip_r, tip_f, pos_f;
    int                t_f[5], t_r[5];
    initial
    begin
        forever #4 clock = ~clock;
    end
    vst_timing_outputs #(.NO_VIDEO_CYC(2000)) dut
    (
        .clock(clock), .rst(rst), .sync_tip_in(sync_tip_in),
        .sync_pos_in(sync_pos_in), .fmt(fmt), .sync_out(so)
    );
    vst_count_rx u_rx
    (
        .clock(clock), .rst(rst), .line_sync(so.line_sync), .field_sync(so.field_sync),
        .serial(so.line_count_serial), .count(rx_count), .composite(rx_comp)
    );
    // edge times of every output, and the hang limit
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        so_d <= so;
        for (int i = 0; i < 5; i++)
        begin
            if (so_d[i] && !so[i]) t_f[i] = cyc;
            if (!so_d[i] && so[i]) t_r[i] = cyc;
        end
        if (cyc > 80000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clock) #1;
    endtask
    task automatic chk(input string nm, input int lo, input int hi, input logic [31:0] seen);
        total_checks++;
        if ((seen >= lo && seen <= hi) !== 1'h1)
        begin
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
            err_count++;
        end
    endtask
    // one sync tip, optional positive half, rest of segment low
    task automatic seg(input int tip, input int len, input int pos);
        tip_r = cyc;
        sync_tip_in = 1'h1;
        tick(tip);
        tip_f = cyc;
        sync_tip_in = 1'h0;
        if (pos > 0) sync_pos_in = 1'h1;
        tick(pos);
        pos_f = cyc;
        sync_pos_in = 1'h0;
        tick(len - tip - pos);
    endtask
    // three broad lines then 17 normal; second field starts 220 cycles (just over half a line) late
    task automatic field(input logic second);
        if (second) seg(30, 220, 0);
        repeat (3) seg(200, L, 0);
        chk("field sync start", L / 4 + 1, L / 4 + 8, t_f[3] - tip_r + 2 * L);
        chk("vertical gate width", 139, 141, t_r[2] - t_f[2]);
        repeat (17) seg(30, L, 0);
        chk("field sync width", 3 * L - 3, 3 * L + 3, t_r[3] - t_f[3]);
        chk("field parity", !second, !second, so.field_parity);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_sd_line();
        repeat (4) seg(30, L, 0);
        chk("line sync fall", 3, 5, t_f[4] - tip_r);
        chk("line sync rise", 3, 5, t_r[4] - tip_f);
        chk("sd gate start", D + 2, D + 8, t_f[2] - tip_f);
        chk("sd gate width", 279, 281, t_r[2] - t_f[2]);
    endtask
    task automatic t_ed_hd();
        fmt = '{vst_pkg::VST_ED, 1'h0};
        repeat (2) seg(30, L, 0);
        chk("ed gate width", 139, 141, t_r[2] - t_f[2]);
        fmt = '{vst_pkg::VST_HD, 1'h0};
        repeat (2) seg(30, L, 20);
        chk("hd gate start", D + 2, D + 8, t_f[2] - pos_f);
    endtask
    task automatic t_prog();
        fmt = '{vst_pkg::VST_SD, 1'h0};
        repeat (3) field(1'h0);
        chk("line count", 17, 17, rx_count);
        chk("composite flag", 0, 0, rx_comp);
    endtask
    task automatic t_interlaced();
        fmt = '{vst_pkg::VST_SD, 1'h1};
        field(1'h0);
        field(1'h1);
        chk("parity fall time", t_f[3], t_f[3], t_f[1]);
        field(1'h0);
        chk("parity rise time", t_f[3], t_f[3], t_r[1]);
    endtask
    // tip stuck high: one rising edge, then no input edge
    task automatic t_no_video();
        sync_tip_in = 1'h1;
        tick(2200);
        chk("idle outputs", 7, 7, so[4:2]);
        sync_tip_in = 1'h0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        tick(20);
        chk("outputs in reset", 31, 31, so);
        rst = 1'h0;
        tick(2);
        t_sd_line();
        t_ed_hd();
        t_prog();
        t_interlaced();
        t_no_video();
        tally_and_finish();
    end
endmodule // vst_timing_outputs_tb
